// [src/sleep_ctrl_params.svh]
// constants for the sleep mode controller: field positions, reset values, timing
// assumes inclusion by bare name from the design file and the testbench
`ifndef SLEEP_CTRL_PARAMS_SVH
`define SLEEP_CTRL_PARAMS_SVH

// ************
// sleep control register fields
// ************
`define SCR_ENABLE_BIT      0
`define SCR_MODE_LSB        1
`define SCR_MODE_MSB        3
`define SCR_RESET           8'h00
`define SCR_UPPER_ZERO      4'h0

// ************
// core control register fields
// ************
`define CCR_BOSO_BIT        6
`define CCR_UNLOCK_BIT      5
`define CCR_RESET           8'h00

// ************
// mode encodings
// ************
`define MODE_IDLE           3'h0
`define MODE_NOISE_RED      3'h1
`define MODE_POWER_DOWN     3'h2
`define MODE_POWER_SAVE     3'h3
`define MODE_RSVD_A         3'h4
`define MODE_RSVD_B         3'h5
`define MODE_STANDBY        3'h6
`define MODE_EXT_STANDBY    3'h7

// ************
// timing
// ************
`define CLK_PERIOD_NS       8
`define UNLOCK_WINDOW_CYC   4
`define BOSO_DELAY_CYC      3
`define BOSO_LIFE_CYC       3
`define WAKE_HOLD_CYC       4
`define STANDBY_WAKE_CYC    6
`define BOD_WAKE_NS         60000
`define BOD_WAKE_CYC        ((`BOD_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/sleep_ctrl_pkg.sv]
// types of the sleep mode controller
// assumes the params header sits on the include path
package sleep_ctrl_pkg;
  typedef enum logic [1:0] {
    st_run,
    st_sleep,
    st_startup,
    st_hold
  } sleep_state_t;
endpackage

// [src/sleep_mode_controller.sv]
// sleep mode controller: mode entry, clock gating, wake-up and brown-out sleep-off
// assumes core writes arrive on mclk; wake and reset sources are asynchronous pins
`timescale 1ns/1ps
`include "sleep_ctrl_params.svh"

// What this block does
// - sleep only when enable set and instruction
// - mode 000 idle stops core, flash clocks
// - idle wakes on any enabled interrupt
// - hold core four cycles after start-up
// - register file and memory kept across sleep
// - reset during sleep restarts at reset vector
// - detector off on entry, on at wake
// - about 60 us wake after detector off
// - sleep-off at bit 6, resets zero
// - timed unlock sequence, active later, self-clears
// - mode 001 stops io, core, flash clocks
// - noise reduction wakes on listed sources only
// - converter starts on idle or noise entry
// - async timer counts only in async mode
// - mode 010 power-down, limited wake sources
// - short level wake: wake, no interrupt
// - power-down wake waits reset time-out
// - mode 011 power-save keeps async timer
// - power-save stops unused timer clock sources
// - mode 110 standby, oscillator on, six cycles
// - mode 111 extended standby, six cycles
// - 100 and 101 reserved, upper bits zero
module sleep_mode_controller #(
  parameter int STARTUP_CYC = 16384,
  parameter int BOD_WAKE_CYC = `BOD_WAKE_CYC
) (
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // core register writes
  input  wire logic       scr_we,
  input  wire logic [7:0] scr_wdata,
  input  wire logic       ccr_we,
  input  wire logic [7:0] ccr_wdata,
  input  wire logic       sleep_instr,
  // configuration
  input  wire logic       crystal_selected,
  input  wire logic       adc_enabled,
  input  wire logic       timer_async_mode,
  input  wire logic       timer_sync_mode,
  input  wire logic       global_irq_en,
  input  wire logic [1:0] async_timer_irq_mask,
  // wake sources, asynchronous
  input  wire logic       irq_any,
  input  wire logic       irq_adc_done,
  input  wire logic       irq_twi_match,
  input  wire logic       irq_async_timer,
  input  wire logic       irq_mem_ready,
  input  wire logic       irq_level_ext,
  input  wire logic       irq_pin_change,
  input  wire logic       irq_watchdog,
  input  wire logic       sys_reset_req,
  // register read-back
  output logic [7:0]      sleep_control_register,
  output logic [7:0]      core_control_register,
  // clock and power controls
  output logic            core_clock_en,
  output logic            program_memory_clock_en,
  output logic            peripheral_io_clock_en,
  output logic            oscillator_en,
  output logic            timer_osc_en,
  output logic            timer_clock_en,
  output logic            brownout_detector_en,
  output logic            adc_start,
  // core handshake
  output logic            core_halted,
  output logic            take_irq,
  output logic            resume_at_reset
);

  localparam int CNT_W = 16;

  // counts beyond the counter width would wrap and cut the restart delay short
  if (STARTUP_CYC < 1 || STARTUP_CYC >= 65536 ||
      BOD_WAKE_CYC < 1 || BOD_WAKE_CYC >= 65536) begin
    $error("wake counts must fit in 16 bits and be at least one");
  end

  function automatic logic mode_legal(input logic [2:0] m, input logic xtal);
    mode_legal = (m != `MODE_RSVD_A) && (m != `MODE_RSVD_B) &&
                 ((m != `MODE_STANDBY && m != `MODE_EXT_STANDBY) || xtal);
  endfunction

  // ************
  // pin synchronisers
  // ************
  logic [8:0] wake_s1_r;
  logic [8:0] wake_s2_r;
  logic [8:0] wake_raw;
  assign wake_raw = {sys_reset_req, irq_watchdog, irq_pin_change, irq_level_ext,
                     irq_mem_ready, irq_async_timer, irq_twi_match, irq_adc_done, irq_any};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wake_s1_r <= 9'h000;
      wake_s2_r <= 9'h000;
    end else if (clk_en) begin
      wake_s1_r <= wake_raw;
      wake_s2_r <= wake_s1_r;
    end
  end

  // ************
  // registers
  // ************
  logic       sleep_en_r;
  logic [2:0] mode_r;
  logic       unlock_r;
  logic [2:0] unlock_cnt_r;
  logic       boso_r;
  logic [1:0] boso_delay_r;
  logic [1:0] boso_life_r;
  logic       boso_active;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sleep_en_r <= 1'b0;
      mode_r     <= `MODE_IDLE;
    end else if (clk_en && scr_we) begin
      sleep_en_r <= scr_wdata[`SCR_ENABLE_BIT];
      mode_r     <= scr_wdata[`SCR_MODE_MSB:`SCR_MODE_LSB];
    end
  end

  // unlock then write within four cycles; active three cycles later, lives three cycles
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'h0;
      boso_r       <= 1'b0;
      boso_delay_r <= 2'h0;
      boso_life_r  <= 2'h0;
    end else if (clk_en) begin
      if (ccr_we && ccr_wdata[`CCR_BOSO_BIT] && ccr_wdata[`CCR_UNLOCK_BIT]) begin
        unlock_r     <= 1'b1;
        unlock_cnt_r <= 3'(`UNLOCK_WINDOW_CYC);
      end else if (ccr_we && ccr_wdata[`CCR_BOSO_BIT] && unlock_r) begin
        unlock_r     <= 1'b0;
        boso_r       <= 1'b1;
        boso_delay_r <= 2'(`BOSO_DELAY_CYC);
        boso_life_r  <= 2'(`BOSO_LIFE_CYC);
      end else if (unlock_cnt_r > 3'h1) begin
        unlock_cnt_r <= unlock_cnt_r - 3'h1;
      end else begin
        unlock_r     <= 1'b0;
        unlock_cnt_r <= 3'h0;
      end
      if (boso_r && !(ccr_we && unlock_r)) begin
        if (boso_delay_r != 2'h0)
          boso_delay_r <= boso_delay_r - 2'h1;
        else if (boso_life_r > 2'h1)
          boso_life_r <= boso_life_r - 2'h1;
        else
          boso_r <= 1'b0;
      end
    end
  end

  assign boso_active = boso_r && boso_delay_r == 2'h0;

  assign sleep_control_register = {`SCR_UPPER_ZERO, mode_r, sleep_en_r};
  assign core_control_register  = {1'b0, boso_r, unlock_r, 5'h00};

  // ************
  // sleep sequencer
  // ************
  sleep_ctrl_pkg::sleep_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0]       act_mode_r;
  logic             bod_off_r;
  logic             irq_pend_r;
  logic             wake_hit;
  logic             enter;
  logic             mode_is_save;

  assign enter        = sleep_instr && sleep_en_r && mode_legal(mode_r, crystal_selected);
  assign mode_is_save = act_mode_r == `MODE_POWER_SAVE || act_mode_r == `MODE_EXT_STANDBY;

  // wake source filter per mode
  always_comb begin
    unique case (act_mode_r)
      `MODE_IDLE:
        wake_hit = wake_s2_r[0] | wake_s2_r[8];
      `MODE_NOISE_RED:
        wake_hit = |{wake_s2_r[1], wake_s2_r[2], wake_s2_r[3], wake_s2_r[4],
                     wake_s2_r[5], wake_s2_r[6], wake_s2_r[7], wake_s2_r[8]};
      `MODE_POWER_SAVE, `MODE_EXT_STANDBY:
        wake_hit = |{wake_s2_r[2], wake_s2_r[5], wake_s2_r[6], wake_s2_r[7], wake_s2_r[8]} |
                   (wake_s2_r[3] && global_irq_en && |async_timer_irq_mask);
      default:
        wake_hit = |{wake_s2_r[2], wake_s2_r[5], wake_s2_r[6], wake_s2_r[7],
                     wake_s2_r[8]};
    endcase
  end

  // register file and memory are outside; the core clock is only gated, never reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r         <= sleep_ctrl_pkg::st_run;
      cnt_r           <= '0;
      act_mode_r      <= `MODE_IDLE;
      bod_off_r       <= 1'b0;
      irq_pend_r      <= 1'b0;
      take_irq        <= 1'b0;
      resume_at_reset <= 1'b0;
      adc_start       <= 1'b0;
    end else if (clk_en) begin
      take_irq  <= 1'b0;
      adc_start <= 1'b0;
      unique case (state_r)
        sleep_ctrl_pkg::st_run: begin
          resume_at_reset <= 1'b0;
          if (enter) begin
            state_r    <= sleep_ctrl_pkg::st_sleep;
            act_mode_r <= mode_r;
            bod_off_r  <= boso_active;
            adc_start  <= adc_enabled &&
                          (mode_r == `MODE_IDLE || mode_r == `MODE_NOISE_RED);
          end
        end
        sleep_ctrl_pkg::st_sleep: begin
          if (wake_hit) begin
            state_r         <= sleep_ctrl_pkg::st_startup;
            bod_off_r       <= 1'b0;
            resume_at_reset <= wake_s2_r[8];
            irq_pend_r      <= !wake_s2_r[8];
            // restart delay per mode, the detector wake count instead when detector was off
            if (bod_off_r)
              cnt_r <= CNT_W'(BOD_WAKE_CYC);
            else if (act_mode_r == `MODE_STANDBY || act_mode_r == `MODE_EXT_STANDBY)
              cnt_r <= CNT_W'(`STANDBY_WAKE_CYC);
            else if (act_mode_r == `MODE_POWER_DOWN || act_mode_r == `MODE_POWER_SAVE)
              cnt_r <= CNT_W'(STARTUP_CYC);
            else
              cnt_r <= CNT_W'(1);
          end
        end
        sleep_ctrl_pkg::st_startup: begin
          if (cnt_r > CNT_W'(1)) begin
            cnt_r <= cnt_r - CNT_W'(1);
          end else begin
            state_r <= sleep_ctrl_pkg::st_hold;
            cnt_r   <= CNT_W'(`WAKE_HOLD_CYC);
            // a level wake gone by now still wakes but raises no interrupt
            irq_pend_r <= irq_pend_r && |wake_s2_r[7:0];
          end
        end
        sleep_ctrl_pkg::st_hold: begin
          if (cnt_r > CNT_W'(1)) begin
            cnt_r <= cnt_r - CNT_W'(1);
          end else begin
            state_r    <= sleep_ctrl_pkg::st_run;
            take_irq   <= irq_pend_r;
            irq_pend_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // ************
  // clock and oscillator gating
  // ************
  logic asleep;
  logic deep;
  assign asleep = state_r != sleep_ctrl_pkg::st_run;
  assign deep   = asleep && act_mode_r != `MODE_IDLE && act_mode_r != `MODE_NOISE_RED;

  assign core_halted             = asleep;
  assign core_clock_en           = !asleep;
  assign program_memory_clock_en = !asleep;
  assign peripheral_io_clock_en  = !asleep || act_mode_r == `MODE_IDLE;
  // standby, idle, noise and sync-timer power-save keep the oscillator; power-down and other power-save stop it until start-up runs
  assign oscillator_en = !(state_r == sleep_ctrl_pkg::st_sleep && deep) ||
                         act_mode_r == `MODE_STANDBY || act_mode_r == `MODE_EXT_STANDBY ||
                         (act_mode_r == `MODE_POWER_SAVE && timer_sync_mode);
  // async timer runs only in async mode, and stops in st_sleep for power-down and standby
  assign timer_osc_en   = timer_async_mode && (!deep || mode_is_save ||
                          state_r != sleep_ctrl_pkg::st_sleep);
  assign timer_clock_en = !asleep || act_mode_r == `MODE_IDLE ||
                          (mode_is_save && timer_sync_mode);
  assign brownout_detector_en = !bod_off_r;

  // ************
  // checks
  // ************
  unlock_window_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && ccr_we && ccr_wdata[6] && ccr_wdata[5] ##1 clk_en [*4] ##1 clk_en && !ccr_we
    |-> !unlock_r)
    else $error("unlock not closed after four cycles");
  sleep_gate_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_run && clk_en && !sleep_en_r |=> !core_halted)
    else $error("slept without enable");
  reserved_nop_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_run && clk_en &&
    (mode_r == 3'h4 || mode_r == 3'h5) |=> !core_halted)
    else $error("reserved mode entered sleep");
  upper_zero_a: assert property (@(posedge mclk) disable iff (reset)
    sleep_control_register[7:4] == 4'h0)
    else $error("upper bits nonzero");
  bod_restore_a: assert property (@(posedge mclk) disable iff (reset)
    !core_halted |-> brownout_detector_en)
    else $error("detector off while running");
  hold_four_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(state_r == sleep_ctrl_pkg::st_hold) && clk_en ##1 clk_en [*3] |-> core_halted)
    else $error("core released before four cycles");
  idle_clocks_a: assert property (@(posedge mclk) disable iff (reset)
    core_halted && act_mode_r == 3'h0 |-> !core_clock_en && peripheral_io_clock_en)
    else $error("idle clock gating wrong");
  adc_start_a: assert property (@(posedge mclk) disable iff (reset)
    adc_start |-> $past(adc_enabled) && act_mode_r[2:1] == 2'h0)
    else $error("adc start in wrong mode");

  // wake side: which clocks stay, which sources count, what the core sees after
  noise_clocks_a: assert property (@(posedge mclk) disable iff (reset)
    core_halted && act_mode_r == 3'h1 |-> !peripheral_io_clock_en && !program_memory_clock_en)
    else $error("noise reduction clock gating wrong");
  deep_osc_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_sleep && act_mode_r == 3'h2 |-> !oscillator_en && !timer_osc_en)
    else $error("oscillator running in power-down");
  standby_osc_a: assert property (@(posedge mclk) disable iff (reset)
    core_halted && act_mode_r[2:1] == 2'h3 |-> oscillator_en)
    else $error("standby stopped the oscillator");
  idle_wake_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_sleep && act_mode_r == 3'h0 && clk_en && wake_s2_r[0]
    |=> state_r == sleep_ctrl_pkg::st_startup)
    else $error("idle ignored an enabled interrupt");
  reset_wake_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_sleep && clk_en && wake_s2_r[8] |=> resume_at_reset)
    else $error("reset wake not flagged");
  bod_entry_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_run && clk_en && enter && boso_active |=> !brownout_detector_en)
    else $error("detector kept on at sleep entry");
  irq_after_hold_a: assert property (@(posedge mclk) disable iff (reset)
    take_irq && $past(clk_en) |-> !core_halted && $past(state_r == sleep_ctrl_pkg::st_hold))
    else $error("interrupt taken outside hold end");
  save_mask_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == sleep_ctrl_pkg::st_sleep && act_mode_r == 3'h3 && clk_en && !global_irq_en &&
    wake_s2_r[8:5] == 4'h0 && !wake_s2_r[2] |=> state_r == sleep_ctrl_pkg::st_sleep)
    else $error("power-save woke with interrupts off");

endmodule

// [dv/core_side_model.sv]
// processor core stand-in: register writes, sleep instruction issue
// assumes inputs of the controller are sampled on rising mclk
`timescale 1ns/1ps

module core_side_model (
  // clock
  input  wire logic       mclk,
  // requests toward the controller
  output logic            scr_we,
  output logic [7:0]      scr_wdata,
  output logic            ccr_we,
  output logic [7:0]      ccr_wdata,
  output logic            sleep_instr
);
  initial begin
    scr_we      = 1'b0;
    scr_wdata   = 8'h00;
    ccr_we      = 1'b0;
    ccr_wdata   = 8'h00;
    sleep_instr = 1'b0;
  end

  // ************
  // bus tasks
  // ************
  // data goes to the inverse once released so a stale value cannot pass for a write
  task automatic wr_scr(input logic [7:0] d);
    @(posedge mclk);
    #1;
    scr_we    = 1'b1;
    scr_wdata = d;
    @(posedge mclk);
    #1;
    scr_we    = 1'b0;
    scr_wdata = ~d;
  endtask

  task automatic wr_ccr(input logic [7:0] d);
    @(posedge mclk);
    #1;
    ccr_we    = 1'b1;
    ccr_wdata = d;
    @(posedge mclk);
    #1;
    ccr_we    = 1'b0;
    ccr_wdata = ~d;
  endtask

  task automatic pulse_sleep();
    sleep_instr = 1'b1;
    @(posedge mclk);
    #1;
    sleep_instr = 1'b0;
  endtask

  // enable bit written from en just before the instruction
  task automatic do_sleep(input logic [2:0] m, input logic en);
    wr_scr({4'h0, m, en});
    pulse_sleep();
  endtask

  // unlock then set, second write two cycles after the first
  task automatic bod_off();
    wr_ccr(8'h60);
    wr_ccr(8'h40);
  endtask
endmodule

// [dv/tb_sleep_mode_controller.sv]
// self-checking bench for the sleep mode controller
// assumes the params header is on the include path; short counts set by parameter
`timescale 1ns/1ps
`include "sleep_ctrl_params.svh"

module tb_sleep_mode_controller;
  logic       mclk, reset, crystal_selected;
  logic [8:0] irqs;
  logic       scr_we, ccr_we, sleep_instr;
  logic [7:0] scr_wdata, ccr_wdata, scr_rd, ccr_rd;
  logic       core_en, pm_en, io_en, osc_en, tosc_en, bod_en, adc_start, halted, take_irq, rar;
  logic       clk_en, adc_en, t_async, t_sync, gie, tclk_en;
  logic [1:0] irq_mask;
  int         failures, compares, cyc;

  core_side_model core (.mclk(mclk), .scr_we(scr_we), .scr_wdata(scr_wdata), .ccr_we(ccr_we),
    .ccr_wdata(ccr_wdata), .sleep_instr(sleep_instr));

  sleep_mode_controller #(.STARTUP_CYC(8), .BOD_WAKE_CYC(10)) uut (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .scr_we(scr_we), .scr_wdata(scr_wdata),
    .ccr_we(ccr_we), .ccr_wdata(ccr_wdata), .sleep_instr(sleep_instr),
    .crystal_selected(crystal_selected), .adc_enabled(adc_en), .timer_async_mode(t_async),
    .timer_sync_mode(t_sync), .global_irq_en(gie), .async_timer_irq_mask(irq_mask),
    .irq_any(irqs[0]), .irq_adc_done(irqs[1]), .irq_twi_match(irqs[2]),
    .irq_async_timer(irqs[3]), .irq_mem_ready(irqs[4]), .irq_level_ext(irqs[5]),
    .irq_pin_change(irqs[6]), .irq_watchdog(irqs[7]), .sys_reset_req(irqs[8]),
    .sleep_control_register(scr_rd), .core_control_register(ccr_rd),
    .core_clock_en(core_en), .program_memory_clock_en(pm_en), .peripheral_io_clock_en(io_en),
    .oscillator_en(osc_en), .timer_osc_en(tosc_en), .timer_clock_en(tclk_en),
    .brownout_detector_en(bod_en),
    .adc_start(adc_start), .core_halted(halted), .take_irq(take_irq), .resume_at_reset(rar));

  // ************
  // clock, reset, watchdog
  // ************
  initial begin
    mclk = 1'b0;
    forever #(`CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("BAD timeout expected done seen hang");
      complete_run();
    end
  end

  // ************
  // helpers
  // ************
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // raise one source, drop it after hold cycles (0 keeps it), wait for release
  task automatic wake(input int src, input int hold, output int n, output bit tk, output bit rr);
    n = 0;
    tk = 0;
    rr = 0;
    irqs[src] = 1'b1;
    while (n < 300) begin
      @(posedge mclk);
      #1;
      n++;
      if (take_irq === 1'b1) tk = 1;
      if (hold > 0 && n == hold) irqs[src] = 1'b0;
      if (halted !== 1'b1) break;
    end
    rr = (rar === 1'b1);
    irqs = 9'h000;
  endtask

  task automatic enter(input logic [2:0] m, output bit a);
    core.do_sleep(m, 1'b1);
    a = (adc_start === 1'b1);
    @(posedge mclk);
    #1;
    a = a | (adc_start === 1'b1);
  endtask

  task automatic complete_run();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ************
  // scenarios
  // ************
  task automatic t_reset_and_reads();
    chk("scr reset", 8'h00, scr_rd);
    chk("ccr reset", 8'h00, ccr_rd);
    chk("bod on", 8'h01, {7'h00, bod_en});
    core.wr_scr(8'hF1);
    chk("scr upper", 8'h01, scr_rd);
    core.wr_ccr(8'h40);
    chk("locked off", 8'h00, {7'h00, ccr_rd[6]});
  endtask

  // disabled, reserved, and crystal-less standby requests are ignored
  task automatic t_refused();
    logic [2:0] bad[5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 5; i++) begin
      core.do_sleep(bad[i], i != 0);
      repeat (2) @(posedge mclk);
      #1;
      chk("refused halt", 8'h00, {7'h00, halted});
    end
  endtask

  task automatic t_modes();
    logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [3:0] clk[6] = '{4'h3, 4'h1, 4'h0, 4'h0, 4'h1, 4'h1};
    int cnt[6] = '{1, 1, 8, 8, 6, 6};
    int src[6] = '{0, 1, 6, 3, 6, 3};
    int n;
    bit a, tk, rr;
    for (int i = 0; i < 6; i++) begin
      enter(md[i], a);
      chk("halted", 8'h01, {7'h00, halted});
      chk("clocks", {4'h0, clk[i]}, {4'h0, core_en, pm_en, io_en, osc_en});
      chk("adc start", {7'h00, i < 2}, {7'h00, a});
      if (md[i] == 3'h1 || md[i] == 3'h3 || md[i] == 3'h7)
        chk("timer osc", 8'h01, {7'h00, tosc_en});
      if (i == 1 || i == 2) begin
        irqs[i - 1] = 1'b1;
        repeat (20) @(posedge mclk);
        #1;
        irqs = 9'h000;
        @(posedge mclk);
        #1;
        chk("no wake", 8'h01, {7'h00, halted});
      end
      wake(src[i], 0, n, tk, rr);
      compares++;
      if (n < cnt[i] + 4 || n > cnt[i] + 9) begin
        failures++;
        $display("BAD wake time expected %0d seen %0d", cnt[i] + 7, n);
      end
      chk("irq taken", 8'h01, {7'h00, tk});
      chk("core clock", 8'h01, {7'h00, core_en});
    end
  endtask

  task automatic t_bod_off();
    int n;
    bit tk, rr;
    core.wr_scr(8'h05);
    core.bod_off();
    chk("sleep-off set", 8'h01, {7'h00, ccr_rd[6]});
    repeat (3) @(posedge mclk);
    #1;
    core.pulse_sleep();
    @(posedge mclk);
    #1;
    chk("bod asleep", 8'h00, {7'h00, bod_en});
    @(posedge mclk);
    #1;
    chk("sleep-off cleared", 8'h00, {7'h00, ccr_rd[6]});
    wake(6, 0, n, tk, rr);
    compares++;
    if (n < 14 || n > 19) begin
      failures++;
      $display("BAD bod wake expected 17 seen %0d", n);
    end
    chk("bod back", 8'h01, {7'h00, bod_en});
  endtask

  task automatic t_short_level_and_reset();
    int n;
    bit a, tk, rr;
    enter(3'h2, a);
    wake(5, 4, n, tk, rr);
    chk("short level woke", 8'h00, {7'h00, halted});
    chk("short level irq", 8'h00, {7'h00, tk});
    enter(3'h2, a);
    wake(8, 0, n, tk, rr);
    chk("reset resume", 8'h01, {7'h00, rr});
    chk("reset no irq", 8'h00, {7'h00, tk});
  endtask

  // frozen clock enable, converter off, synchronous timer, masked timer wake
  task automatic t_config();
    int n;
    bit a, tk, rr;
    clk_en = 1'b0;
    core.wr_scr(8'h00);
    chk("frozen write", 8'h05, scr_rd);
    clk_en = 1'b1;
    adc_en = 1'b0;
    t_sync = 1'b1;
    t_async = 1'b0;
    gie = 1'b0;
    enter(3'h3, a);
    chk("adc off", 8'h00, {7'h00, a});
    chk("sync osc", 8'h01, {7'h00, osc_en});
    chk("sync timer clk", 8'h01, {7'h00, tclk_en});
    chk("async osc off", 8'h00, {7'h00, tosc_en});
    irqs[3] = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    gie = 1'b1;
    irq_mask = 2'h0;
    repeat (10) @(posedge mclk);
    #1;
    irqs = 9'h000;
    repeat (3) @(posedge mclk);
    #1;
    chk("masked timer", 8'h01, {7'h00, halted});
    irq_mask = 2'h1;
    wake(3, 0, n, tk, rr);
    chk("timer irq", 8'h01, {7'h00, tk});
    adc_en = 1'b1;
    t_sync = 1'b0;
    t_async = 1'b1;
    irq_mask = 2'h3;
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    failures = 0;
    compares = 0;
    cyc = 0;
    irqs = 9'h000;
    crystal_selected = 1'b0;
    clk_en = 1'b1;
    adc_en = 1'b1;
    t_async = 1'b1;
    t_sync = 1'b0;
    gie = 1'b1;
    irq_mask = 2'h3;
    reset = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_reset_and_reads();
    t_refused();
    crystal_selected = 1'b1;
    t_modes();
    t_bod_off();
    t_short_level_and_reset();
    t_config();
    complete_run();
  end
endmodule
